// ==== dpc_top.sv ====
module dpc_top #(
    parameter int OUT_PULSE_CYC   = dpc_pkg::OUT_PULSE_CYC,
    parameter int BTN_LOCKOUT_CYC = dpc_pkg::BTN_LOCKOUT_CYC
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    input  wire logic [dpc_pkg::ADDR_W-1:0]    wb_adr_i,
    input  wire logic [31:0]                    wb_dat_i,
    output logic      [31:0]                    wb_dat_o,
    input  wire logic                           wb_we_i,
    input  wire logic [3:0]                     wb_sel_i,
    input  wire logic                           wb_stb_i,
    input  wire logic                           wb_cyc_i,
    output logic                                wb_ack_o,
    input  wire logic                           channel_one_in_i,
    input  wire logic                           channel_two_in_i,
    input  wire logic                           hold_i,
    input  wire logic                           clear_btn_i,
    input  wire logic                           select_btn_i,
    output logic                                channel_one_out_o,
    output logic                                channel_two_out_o,
    output logic      [dpc_pkg::COUNT_W-1:0]   disp_count_o,
    output logic                                disp_chan_two_o,
    output logic                                irq_o
);

    localparam int NCH   = dpc_pkg::NUM_CH;
    localparam int LCK_W = $clog2(BTN_LOCKOUT_CYC + 1);
    localparam logic [LCK_W-1:0] LCK_LOAD = LCK_W'(BTN_LOCKOUT_CYC);

    // ------------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------------
    logic [dpc_pkg::SYN_W-1:0] syn;
    logic [dpc_pkg::SYN_W-1:0] syn_prev_q;

    dpc_sync #(
        .W (dpc_pkg::SYN_W)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i ({select_btn_i, clear_btn_i, hold_i, channel_two_in_i, channel_one_in_i}),
        .sync_o  (syn)
    );

    // edge detection looks only at the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) syn_prev_q <= '0;
        else       syn_prev_q <= syn;
    end

    wire [dpc_pkg::SYN_W-1:0] rise = syn & ~syn_prev_q;
    wire                      hold = syn[dpc_pkg::SYN_HOLD];

    // ------------------------------------------------------------------
    // push-button lockout: contacts bounce, so one press gives one event
    // ------------------------------------------------------------------
    logic [1:0] btn_ev;
    wire  [1:0] btn_rise = {rise[dpc_pkg::SYN_SEL], rise[dpc_pkg::SYN_CLEAR]};

    for (genvar b = 0; b < 2; b++) begin : g_btn
        logic [LCK_W-1:0] lck_q;
        assign btn_ev[b] = btn_rise[b] & (lck_q == '0);
        // rearms only after the lockout has run out
        always_ff @(posedge clk_i) begin
            if (rst_i)            lck_q <= '0;
            else if (btn_ev[b])   lck_q <= LCK_LOAD;
            else if (lck_q != '0) lck_q <= lck_q - 1'b1;
        end
    end

    wire clear_ev  = btn_ev[0];
    wire select_ev = btn_ev[1];

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic                     two_ch_q;
    logic                     disp_sel_q;
    logic [dpc_pkg::IRQ_W-1:0] irq_st_q, irq_msk_q;
    logic                     ack_q;
    logic [31:0]              rdat_q;
    logic [dpc_pkg::COUNT_W-1:0] disp_q;
    logic                     disp_two_q;
    logic                     irq_q;

    // ------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------
    logic [dpc_pkg::COUNT_W-1:0] cnt [NCH];
    logic [NCH-1:0]              ovf, wrap, outp, ch_en;

    assign ch_en = {two_ch_q, 1'b1};

    for (genvar c = 0; c < NCH; c++) begin : g_ch
        dpc_chan #(
            .PULSE_CYC (OUT_PULSE_CYC)
        ) u_chan (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .enable_i (ch_en[c]),
            .pulse_i  (rise[c]),
            .hold_i   (hold),
            .clear_i  (clear_ev),
            .count_o  (cnt[c]),
            .ovf_o    (ovf[c]),
            .wrap_o   (wrap[c]),
            .out_o    (outp[c])
        );
    end

    assign channel_one_out_o = outp[0];
    assign channel_two_out_o = outp[1];

    // ------------------------------------------------------------------
    // wishbone decode
    // ------------------------------------------------------------------
    wire req      = wb_cyc_i & wb_stb_i & ~ack_q;
    wire wr_lo    = req & wb_we_i & wb_sel_i[0];
    wire hit_ctrl = (wb_adr_i == dpc_pkg::ADDR_CTRL);
    wire hit_stat = (wb_adr_i == dpc_pkg::ADDR_STATUS);
    wire hit_c1   = (wb_adr_i == dpc_pkg::ADDR_COUNT1);
    wire hit_c2   = (wb_adr_i == dpc_pkg::ADDR_COUNT2);
    wire hit_ist  = (wb_adr_i == dpc_pkg::ADDR_IRQ_ST);
    wire hit_imsk = (wb_adr_i == dpc_pkg::ADDR_IRQ_MSK);

    wire [dpc_pkg::IRQ_W-1:0] irq_clr = (wr_lo && hit_ist) ? wb_dat_i[dpc_pkg::IRQ_W-1:0] : '0;
    wire [dpc_pkg::IRQ_W-1:0] irq_set = {wrap & ch_en, rise[NCH-1:0] & ch_en};
    wire                      irq_any = |(irq_st_q & irq_msk_q);

    wire [31:0] stat_word = {{(32 - dpc_pkg::STAT_OVF_LSB - NCH){1'b0}}, ovf, hold, disp_sel_q};

    // unmapped addresses read as zero and are still acknowledged
    wire [31:0] rd_mux =
        hit_ctrl ? {31'h00000000, two_ch_q} :
        hit_stat ? stat_word :
        hit_c1   ? {8'h00, cnt[0]} :
        hit_c2   ? {8'h00, cnt[1]} :
        hit_ist  ? {28'h0000000, irq_st_q} :
        hit_imsk ? {28'h0000000, irq_msk_q} : 32'h00000000;

    // select toggles only while channel two is active
    wire disp_sel_d = !two_ch_q ? 1'b0 : (select_ev ? ~disp_sel_q : disp_sel_q);

    // bus slave: one-cycle answer, ack drops the next cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q  <= req;
            rdat_q <= req ? rd_mux : rdat_q;
        end
    end

    // software control and interrupt registers; a set beats a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            two_ch_q  <= dpc_pkg::CTRL_TWO_CH_RST;
            irq_msk_q <= dpc_pkg::IRQ_MSK_RST;
            irq_st_q  <= '0;
        end else begin
            if (wr_lo && hit_ctrl) two_ch_q <= wb_dat_i[dpc_pkg::CTRL_TWO_CH_BIT];
            if (wr_lo && hit_imsk) irq_msk_q <= wb_dat_i[dpc_pkg::IRQ_W-1:0];
            irq_st_q <= irq_set | (irq_st_q & ~irq_clr);
        end
    end

    // display and interrupt outputs all from flops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            disp_sel_q <= 1'b0;
            disp_q     <= '0;
            disp_two_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            disp_sel_q <= disp_sel_d;
            disp_q     <= disp_sel_q ? cnt[1] : cnt[0];
            disp_two_q <= disp_sel_q;
            irq_q      <= irq_any;
        end
    end

    assign wb_ack_o        = ack_q;
    assign wb_dat_o        = rdat_q;
    assign disp_count_o    = disp_q;
    assign disp_chan_two_o = disp_two_q;
    assign irq_o           = irq_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence

    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_req |=> s_ack_once)
        else $error("bus answer not a single cycle");

    hold_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (hold && $past(hold) && !clear_ev) |=> $stable(cnt[0]) && $stable(cnt[1]))
        else $error("count moved while held");

    sequence s_resume;
        !hold && rise[0] && !clear_ev && cnt[0] != dpc_pkg::COUNT_MAX;
    endsequence

    resume_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
        s_resume |=> cnt[0] == $past(cnt[0]) + 1'b1)
        else $error("counting did not resume from held value");

    clear_both_a: assert property (@(posedge clk_i) disable iff (rst_i)
        clear_ev |=> cnt[0] == '0 && cnt[1] == '0 && ovf == '0)
        else $error("clear left a counter nonzero");

    select_toggle_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (select_ev && two_ch_q) |=> ##1 disp_chan_two_o != $past(disp_chan_two_o, 2))
        else $error("display channel did not toggle");

    single_chan_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!two_ch_q && !$past(two_ch_q)) |=> $stable(cnt[1]) || cnt[1] == '0)
        else $error("channel two counted while disabled");

    out_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rise[0] && !channel_one_out_o && g_ch[0].u_chan.pend_q == '0
         && g_ch[0].u_chan.tmr_q == '0) |=> channel_one_out_o)
        else $error("accepted pulse not repeated");

    irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 irq_o == $past(irq_any))
        else $error("interrupt output wrong");

    irq_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (irq_set[0] && !irq_st_q[0]) |=> irq_st_q[0])
        else $error("event flag not set");

endmodule

// ==== dpc_pkg.sv ====
package dpc_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS     = 10;
    localparam int OUT_PULSE_MIN_NS  = 4_000_000;
    // strictly longer than the minimum, so one extra cycle
    localparam int OUT_PULSE_CYC     = OUT_PULSE_MIN_NS / CLK_PERIOD_NS + 1;
    localparam int BTN_LOCKOUT_NS    = 20_000_000;
    localparam int BTN_LOCKOUT_CYC   = BTN_LOCKOUT_NS / CLK_PERIOD_NS;

    // counter range, seven decimal digits
    localparam int          COUNT_W   = 24;
    localparam logic [23:0] COUNT_MAX = 24'h98967F;
    localparam int          NUM_CH    = 2;

    // register map, byte addresses
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_COUNT1  = 8'h08;
    localparam logic [7:0] ADDR_COUNT2  = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ST  = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h14;

    // control fields
    localparam int   CTRL_TWO_CH_BIT = 0;
    localparam logic CTRL_TWO_CH_RST = 1'b1;

    // status fields
    localparam int STAT_DISP_BIT = 0;
    localparam int STAT_HOLD_BIT = 1;
    localparam int STAT_OVF_LSB  = 2;

    // interrupt fields: accepted pulse per channel, then wrap per channel
    localparam int         IRQ_W         = 4;
    localparam int         IRQ_PULSE_LSB = 0;
    localparam int         IRQ_WRAP_LSB  = 2;
    localparam logic [3:0] IRQ_MSK_RST   = 4'h0;

    // synchroniser bit positions
    localparam int SYN_HOLD  = 2;
    localparam int SYN_CLEAR = 3;
    localparam int SYN_SEL   = 4;
    localparam int SYN_W     = 5;

endpackage

// ==== dpc_sync.sv ====
// two-stage synchroniser for asynchronous pins
module dpc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// ==== dpc_chan.sv ====
// one counting channel with its repeated pulse output
module dpc_chan #(
    parameter int PULSE_CYC = dpc_pkg::OUT_PULSE_CYC,
    parameter int PEND_W    = 4
) (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         enable_i,
    input  wire logic                         pulse_i,
    input  wire logic                         hold_i,
    input  wire logic                         clear_i,
    output logic      [dpc_pkg::COUNT_W-1:0] count_o,
    output logic                              ovf_o,
    output logic                              wrap_o,
    output logic                              out_o
);

    localparam int TMR_W = $clog2(PULSE_CYC + 1);
    localparam logic [TMR_W-1:0]  TMR_LOAD = TMR_W'(PULSE_CYC);
    localparam logic [PEND_W-1:0] PEND_MAX = '1;

    logic [dpc_pkg::COUNT_W-1:0] cnt_q, cnt_d;
    logic                        ovf_q, wrap_q;
    logic [TMR_W-1:0]            tmr_q, tmr_d;
    logic [PEND_W-1:0]           pend_q, pend_d;
    logic                        out_q;
    wire                         acc      = pulse_i & enable_i;
    wire                         count_en = acc & ~hold_i;
    wire                         at_max   = (cnt_q == dpc_pkg::COUNT_MAX);
    wire                         wrap     = count_en & at_max & ~clear_i;
    wire                         idle     = (tmr_q == '0);
    wire                         start    = idle & ((pend_q != '0) | acc);

    // counter: clear first, hold freezes, wraps past the top
    assign cnt_d = clear_i  ? '0 :
                   !count_en ? cnt_q :
                   at_max    ? '0 : cnt_q + 1'b1;

    // output pulses queue up, at most 15 waiting; an accepted input that finds the queue full is dropped
    assign pend_d = (acc && !start && pend_q != PEND_MAX) ? pend_q + 1'b1 :
                    (!acc && start && pend_q != '0)       ? pend_q - 1'b1 : pend_q;
    assign tmr_d  = start ? TMR_LOAD : (idle ? '0 : tmr_q - 1'b1);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            ovf_q  <= 1'b0;
            wrap_q <= 1'b0;
            tmr_q  <= '0;
            pend_q <= '0;
            out_q  <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            ovf_q  <= wrap | (ovf_q & ~clear_i);
            wrap_q <= wrap;
            tmr_q  <= tmr_d;
            pend_q <= pend_d;
            out_q  <= (tmr_d != '0);
        end
    end

    assign count_o = cnt_q;
    assign ovf_o   = ovf_q;
    assign wrap_o  = wrap_q;
    assign out_o   = out_q;

    // pulse width watched by a helper counter
    logic [TMR_W-1:0] hi_len_q;
    always_ff @(posedge clk_i) begin
        if (rst_i) hi_len_q <= '0;
        else       hi_len_q <= out_q ? hi_len_q + 1'b1 : '0;
    end

    out_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(out_q) |-> $past(hi_len_q) == TMR_LOAD - 1'b1)
        else $error("output pulse width wrong");

    wrap_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (count_en && at_max && !clear_i) |=> (cnt_q == '0) && ovf_q && wrap_q)
        else $error("counter did not wrap with overflow");

endmodule

// ==== dpc_flow_model.sv ====
// flow transmitter driving one input, plus test gear watching the repeated output
module dpc_flow_model #(
    parameter int HIGH_CYC = 5,
    parameter int LOW_CYC  = 7
) (
    input  wire logic        clk_i,
    input  wire logic [3:0]  burst_i,
    input  wire logic        go_i,
    input  wire logic        out_i,
    output logic             pulse_o,
    output logic             busy_o,
    output logic [7:0]       seen_o,
    output logic [23:0]      width_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0]  left_q  = 4'h0;
    logic [7:0]  phase_q = 8'h00;
    logic [23:0] run_q   = 24'h000000;
    logic        out_q   = 1'b0;
    logic        pulse_q = 1'b0;
    logic [7:0]  seen_q  = 8'h00;
    logic [23:0] width_q = 24'h000000;

    // one driver per output: the flops below, except busy_o, decoded from left_q and go_i
    assign pulse_o = pulse_q;
    assign seen_o  = seen_q;
    assign width_o = width_q;
    assign busy_o  = (left_q != 4'h0) | go_i;

    // clean edges, never bounced, high long enough for the sampler
    always @(posedge clk_i) begin
        if (go_i && left_q == 4'h0) begin
            left_q  <= burst_i;
            phase_q <= 8'h00;
        end else if (left_q != 4'h0) begin
            pulse_q <= (phase_q < HIGH_CYC);
            phase_q <= (phase_q == HIGH_CYC + LOW_CYC - 1) ? 8'h00 : phase_q + 8'h01;
            if (phase_q == HIGH_CYC + LOW_CYC - 1) begin
                left_q <= left_q - 4'h1;
            end
        end else begin
            pulse_q <= 1'b0;
        end
    end

    // test gear side: count output pulses, measure the last high time
    always @(posedge clk_i) begin
        out_q <= out_i;
        run_q <= out_i ? run_q + 24'h000001 : run_q;
        if (out_i && !out_q) begin
            seen_q <= seen_q + 8'h01;
            run_q  <= 24'h000001;
        end
        if (!out_i && out_q) begin
            width_q <= run_q;
        end
    end
endmodule

// ==== tb_top.sv ====
`define CHK(got, exp, msg) \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("MISMATCH t=%0t %s got %0h exp %0h", $time, msg, got, exp); \
    end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;

    // short pulse and lockout so the run stays small
    localparam int OUT_CYC  = 20;
    localparam int LOCK_CYC = 8;

    typedef struct {
        logic [7:0]  a;
        logic [31:0] e;
    } dpc_row_t;

    logic        clk_i           = 1'b0;
    logic        rst_i           = 1'b1;
    logic [7:0]  wb_adr_i        = 8'h00;
    logic [31:0] wb_dat_i        = 32'h00000000;
    logic        wb_we_i         = 1'b0;
    logic [3:0]  wb_sel_i        = 4'h0;
    logic        wb_stb_i        = 1'b0;
    logic        wb_cyc_i        = 1'b0;
    logic        hold_i          = 1'b0;
    logic        clear_btn_i     = 1'b0;
    logic        select_btn_i    = 1'b0;
    logic        go              = 1'b0;
    logic [3:0]  n1              = 4'h0;
    logic [3:0]  n2              = 4'h0;
    logic [31:0] wb_dat_o;
    logic [31:0] rd;
    logic        wb_ack_o, in1, in2, out1, out2, chan_two, irq_o, busy1, busy2;
    logic [23:0] disp, w1, w2;
    logic [7:0]  seen1, seen2;
    int          mismatches      = 0;
    int          samples_checked = 0;
    dpc_row_t    rows [7]        = '{'{dpc_pkg::ADDR_CTRL, 32'h00000001}, '{dpc_pkg::ADDR_STATUS, 32'h00000000},
                                     '{dpc_pkg::ADDR_COUNT1, 32'h00000000}, '{dpc_pkg::ADDR_COUNT2, 32'h00000000},
                                     '{dpc_pkg::ADDR_IRQ_ST, 32'h00000000}, '{dpc_pkg::ADDR_IRQ_MSK, 32'h00000000},
                                     '{8'h20, 32'h00000000}};

    dpc_top #(.OUT_PULSE_CYC(OUT_CYC), .BTN_LOCKOUT_CYC(LOCK_CYC)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
        .channel_one_in_i(in1), .channel_two_in_i(in2), .hold_i(hold_i), .clear_btn_i(clear_btn_i),
        .select_btn_i(select_btn_i), .channel_one_out_o(out1), .channel_two_out_o(out2),
        .disp_count_o(disp), .disp_chan_two_o(chan_two), .irq_o(irq_o));

    dpc_flow_model i_src1 (.clk_i(clk_i), .burst_i(n1), .go_i(go), .out_i(out1), .pulse_o(in1),
                           .busy_o(busy1), .seen_o(seen1), .width_o(w1));
    dpc_flow_model i_src2 (.clk_i(clk_i), .burst_i(n2), .go_i(go), .out_i(out2), .pulse_o(in2),
                           .busy_o(busy2), .seen_o(seen2), .width_o(w2));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    task automatic close_out();
        $display("TB: checks=%0d mismatches=%0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // one classic cycle; request held until ack is seen at an edge
    task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] q);
        int n;
        n = 0;
        wb_adr_i <= a;
        wb_we_i  <= we;
        wb_dat_i <= d;
        wb_sel_i <= s;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        q = wb_dat_o;
        if (n >= 100) begin
            mismatches++;
            close_out();
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] q;
        xfer(a, 1'b1, d, s, q);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        xfer(a, 1'b0, 32'h00000000, 4'hF, rd);
        `CHK(rd, e, "register read")
    endtask

    // both sources start together; wait until all output pulses are out
    task automatic burst(input logic [3:0] a, input logic [3:0] b);
        int quiet;
        int k;
        quiet = 0;
        k = 0;
        n1 <= a;
        n2 <= b;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        while (quiet < 5) begin
            @(posedge clk_i);
            k++;
            quiet = (busy1 | busy2 | out1 | out2) ? 0 : quiet + 1;
            if (k > 3000) begin
                mismatches++;
                close_out();
            end
        end
    endtask

    // held past the sync, then released well past the lockout
    task automatic press(input logic sel);
        select_btn_i <= sel;
        clear_btn_i  <= ~sel;
        repeat (4) @(posedge clk_i);
        select_btn_i <= 1'b0;
        clear_btn_i  <= 1'b0;
        repeat (LOCK_CYC + 4) @(posedge clk_i);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        foreach (rows[i]) begin
            rd_chk(rows[i].a, rows[i].e);
        end
        $display("TB: test reset_values done");
        burst(4'h3, 4'h2);
        rd_chk(dpc_pkg::ADDR_COUNT1, 32'h00000003);
        rd_chk(dpc_pkg::ADDR_COUNT2, 32'h00000002);
        `CHK(seen1, 8'h03, "ch1 pulses out")
        `CHK(seen2, 8'h02, "ch2 pulses out")
        `CHK(w1, 24'(OUT_CYC), "out width")
        `CHK(disp, 24'h000003, "display count")
        $display("TB: test counting done");
        rd_chk(dpc_pkg::ADDR_IRQ_ST, 32'h00000003);
        `CHK(irq_o, 1'b0, "irq masked")
        wr(dpc_pkg::ADDR_IRQ_MSK, 32'h00000001, 4'hF);
        `CHK(irq_o, 1'b1, "irq unmasked")
        wr(dpc_pkg::ADDR_IRQ_ST, 32'h00000001, 4'hF);
        `CHK(irq_o, 1'b0, "irq cleared")
        rd_chk(dpc_pkg::ADDR_IRQ_ST, 32'h00000002);
        $display("TB: test interrupt done");
        hold_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        burst(4'h2, 4'h0);
        rd_chk(dpc_pkg::ADDR_COUNT1, 32'h00000003);
        rd_chk(dpc_pkg::ADDR_STATUS, 32'h00000002);
        `CHK(seen1, 8'h05, "out during hold")
        hold_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        burst(4'h1, 4'h0);
        rd_chk(dpc_pkg::ADDR_COUNT1, 32'h00000004);
        $display("TB: test hold done");
        press(1'b1);
        `CHK(chan_two, 1'b1, "shown ch2")
        `CHK(disp, 24'h000002, "ch2 count shown")
        rd_chk(dpc_pkg::ADDR_STATUS, 32'h00000001);
        press(1'b1);
        `CHK(chan_two, 1'b0, "shown ch1")
        `CHK(disp, 24'h000004, "ch1 count shown")
        press(1'b0);
        rd_chk(dpc_pkg::ADDR_COUNT1, 32'h00000000);
        rd_chk(dpc_pkg::ADDR_COUNT2, 32'h00000000);
        $display("TB: test buttons done");
        // lane 0 off: write must be dropped
        wr(dpc_pkg::ADDR_CTRL, 32'h00000000, 4'hE);
        rd_chk(dpc_pkg::ADDR_CTRL, 32'h00000001);
        wr(dpc_pkg::ADDR_CTRL, 32'h00000000, 4'hF);
        burst(4'h2, 4'h2);
        rd_chk(dpc_pkg::ADDR_COUNT1, 32'h00000002);
        rd_chk(dpc_pkg::ADDR_COUNT2, 32'h00000000);
        `CHK(seen2, 8'h02, "ch2 out idle")
        press(1'b1);
        `CHK(chan_two, 1'b0, "single channel shown")
        $display("TB: test single_channel done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(dpc_pkg::ADDR_CTRL, 32'h00000001);
        rd_chk(dpc_pkg::ADDR_COUNT1, 32'h00000000);
        $display("TB: test second_reset done");
        close_out();
    end
endmodule
